// *** hw/dbc_regs.svh ***
// Field positions and reset values of the debug control block registers.
// Assumes it is included by the design modules.
`ifndef DBC_REGS_SVH
`define DBC_REGS_SVH

// Status and control register fields
`define DBC_SCR_PERMIT_BIT 7
`define DBC_SCR_ACTIVE_BIT 6
`define DBC_SCR_BKPT_EN_BIT 5
`define DBC_SCR_FTS_BIT 4
`define DBC_SCR_CLKSEL_BIT 3
`define DBC_SCR_WS_BIT 2
`define DBC_SCR_WSF_BIT 1
`define DBC_SCR_DVF_BIT 0

// Register widths and reset values
`define DBC_SCR_WIDTH 8
`define DBC_BKPT_WIDTH 16
`define DBC_BKPT_RESET 16'h0000
`define DBC_BIT_RESET 1'h0

`endif

// *** hw/dbc_pkg.sv ***
// Types shared by the debug control block modules.
// Assumes the serial command decoder uses the same command encoding.
package dbc_pkg;

   // Commands handed over by the serial link decoder
   typedef enum logic [2:0]
   {
      cmd_read_status,
      cmd_write_control,
      cmd_read_bkpt,
      cmd_write_bkpt,
      cmd_background,
      cmd_go
   } dbc_cmd_t;

   // Processor state as seen by the debug logic
   typedef enum logic
   {
      mode_run,
      mode_active
   } dbc_mode_t;

endpackage

// *** hw/dbc_addr_match.sv ***
// Exact-equality comparator of a bus address against the match value.
// Assumes address and match value are on the same clock; purely combinational.
module dbc_addr_match
#(
   parameter int WIDTH = 16
)
(
   // Compare operands
   input wire logic [WIDTH-1:0] i_addr,
   input wire logic [WIDTH-1:0] i_match,
   // Qualifiers
   input wire logic i_enable,
   input wire logic i_access,
   // Result
   output logic o_hit
);

   // Every address bit takes part; a partial compare would alias breakpoints
   always_comb
   begin
      o_hit = i_enable && i_access && (i_addr == i_match); // RL19
   end

endmodule

// *** hw/dbc_ctrl_status.sv ***
// Control, status and hardware breakpoint logic of the serial debug controller.
// Assumes a decoder on the same clock hands over commands one cycle each.
// Function
// [RL1] Eight-bit status and control register provided
// [RL2] Sixteen-bit match register compared against address
// [RL3] Registers reachable only by debug commands
// [RL4] Permit bit frozen while background is active
// [RL5] Four status bits ignore control writes
// [RL6] Permit low refuses entry; reset clears
// [RL7] Active bit reports background mode
// [RL8] Breakpoint disabled requests nothing at all
// [RL9] Force mode enters at next instruction boundary
// [RL10] Tag mode marks opcode, enters at queue end
// [RL11] Clock select resets low, always writable
// [RL12] Wait/stop flag shows wait or woken
// [RL13] Background command wakes from wait/stop
// [RL14] Host confirms active bit after forcing
// [RL15] Wait/stop failure flag set on failure
// [RL16] Host recovers failures via background command
// [RL17] Data valid failure always reads zero
// [RL18] Breakpoint enable is low after reset
// [RL19] Comparator needs exact sixteen-bit equality
`include "dbc_regs.svh"

module dbc_ctrl_status
#(
   parameter int ADDR_WIDTH = `DBC_BKPT_WIDTH
)
(
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_nrst,
   // Commands from the serial link decoder
   input wire logic i_cmd_valid,
   input dbc_pkg::dbc_cmd_t i_cmd,
   input wire logic [15:0] i_cmd_wdata,
   output logic [15:0] o_rdata_ff,
   output logic o_rdata_valid_ff,
   // Processor bus and pipeline
   input wire logic i_cpu_access,
   input wire logic i_cpu_opfetch,
   input wire logic [ADDR_WIDTH-1:0] i_cpu_addr,
   input wire logic i_instr_boundary,
   input wire logic i_tag_at_queue_end,
   input wire logic i_cpu_wait_stop,
   input wire logic i_mem_fail_ws,
   // Requests and state toward the processor
   output logic o_enter_bgnd_ff,
   output logic o_opcode_tag_ff,
   output logic o_background_active_ff,
   output logic o_comm_clock_select_ff
);

   // Control fields, written by debug commands only
   logic background_permit_ff;
   logic nxt_background_permit;
   logic breakpoint_enable_ff;
   logic nxt_breakpoint_enable;
   logic force_or_tag_choice_ff;
   logic nxt_force_or_tag_choice;
   logic comm_clock_select_ff;
   logic nxt_comm_clock_select;
   logic [ADDR_WIDTH-1:0] breakpoint_match_address_ff;
   logic [ADDR_WIDTH-1:0] nxt_breakpoint_match_address;

   // Mode and status state
   dbc_pkg::dbc_mode_t mode_ff;
   dbc_pkg::dbc_mode_t nxt_mode;
   logic ws_wake_ff;
   logic nxt_ws_wake;
   logic wait_stop_failure_ff;
   logic nxt_wait_stop_failure;
   logic force_pend_ff;
   logic nxt_force_pend;

   // Output registers
   logic enter_ff;
   logic nxt_enter;
   logic tag_ff;
   logic nxt_tag;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   logic rvalid_ff;
   logic nxt_rvalid;

   // Decoded command strobes
   logic wr_ctrl;
   logic wr_bkpt;
   logic rd_status;
   logic rd_bkpt;
   logic bg_cmd;
   logic go_cmd;
   // Comparator result and assembled status byte
   logic addr_hit;
   logic wait_stop_flag;
   logic [`DBC_SCR_WIDTH-1:0] status_byte;

   // Command decode; no processor data port exists, so user code cannot reach these
   always_comb
   begin
      wr_ctrl = i_cmd_valid && (i_cmd == dbc_pkg::cmd_write_control); // RL3
      wr_bkpt = i_cmd_valid && (i_cmd == dbc_pkg::cmd_write_bkpt); // RL3
      rd_status = i_cmd_valid && (i_cmd == dbc_pkg::cmd_read_status);
      rd_bkpt = i_cmd_valid && (i_cmd == dbc_pkg::cmd_read_bkpt);
      bg_cmd = i_cmd_valid && (i_cmd == dbc_pkg::cmd_background);
      go_cmd = i_cmd_valid && (i_cmd == dbc_pkg::cmd_go);
   end

   // Breakpoint comparator, only live while the user program runs
   dbc_addr_match
   #(
      .WIDTH(ADDR_WIDTH)
   )
   u_match
   (
      .i_addr(i_cpu_addr),
      .i_match(breakpoint_match_address_ff),
      .i_enable(breakpoint_enable_ff && (mode_ff == dbc_pkg::mode_run)), // RL2 RL8
      .i_access(i_cpu_access),
      .o_hit(addr_hit)
   );

   // Wait/stop flag: live wait/stop level, or held after a wake into background
   always_comb
   begin
      wait_stop_flag = i_cpu_wait_stop || ws_wake_ff; // RL12
   end

   // Status byte as the host reads it; failure bit for slow memory never rises
   always_comb
   begin
      status_byte = '0;
      status_byte[`DBC_SCR_PERMIT_BIT] = background_permit_ff; // RL1
      status_byte[`DBC_SCR_ACTIVE_BIT] = (mode_ff == dbc_pkg::mode_active); // RL7
      status_byte[`DBC_SCR_BKPT_EN_BIT] = breakpoint_enable_ff;
      status_byte[`DBC_SCR_FTS_BIT] = force_or_tag_choice_ff;
      status_byte[`DBC_SCR_CLKSEL_BIT] = comm_clock_select_ff;
      status_byte[`DBC_SCR_WS_BIT] = wait_stop_flag;
      status_byte[`DBC_SCR_WSF_BIT] = wait_stop_failure_ff;
      status_byte[`DBC_SCR_DVF_BIT] = 1'h0; // RL17
   end

   // Control register next values
   always_comb
   begin
      nxt_background_permit = background_permit_ff;
      nxt_breakpoint_enable = breakpoint_enable_ff;
      nxt_force_or_tag_choice = force_or_tag_choice_ff;
      nxt_comm_clock_select = comm_clock_select_ff;
      nxt_breakpoint_match_address = breakpoint_match_address_ff;
      if (wr_ctrl)
      begin
         // Permit may not forbid a mode that is already active
         if (mode_ff == dbc_pkg::mode_run)
         begin
            nxt_background_permit = i_cmd_wdata[`DBC_SCR_PERMIT_BIT]; // RL4
         end
         nxt_breakpoint_enable = i_cmd_wdata[`DBC_SCR_BKPT_EN_BIT];
         nxt_force_or_tag_choice = i_cmd_wdata[`DBC_SCR_FTS_BIT];
         nxt_comm_clock_select = i_cmd_wdata[`DBC_SCR_CLKSEL_BIT]; // RL11
         // Active, wait/stop and failure bits take nothing from the write
      end
      if (wr_bkpt)
      begin
         nxt_breakpoint_match_address = i_cmd_wdata[ADDR_WIDTH-1:0]; // RL2
      end
   end

   // Control registers; reset clears the permit bit, a control write while running loads it from bit 7
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         background_permit_ff <= `DBC_BIT_RESET; // RL6
         breakpoint_enable_ff <= `DBC_BIT_RESET; // RL18
         force_or_tag_choice_ff <= `DBC_BIT_RESET;
         comm_clock_select_ff <= `DBC_BIT_RESET; // RL11
         breakpoint_match_address_ff <= ADDR_WIDTH'(`DBC_BKPT_RESET);
      end
      else
      begin
         background_permit_ff <= nxt_background_permit;
         breakpoint_enable_ff <= nxt_breakpoint_enable;
         force_or_tag_choice_ff <= nxt_force_or_tag_choice;
         comm_clock_select_ff <= nxt_comm_clock_select;
         breakpoint_match_address_ff <= nxt_breakpoint_match_address;
      end
   end

   // Mode, breakpoint and status next values
   always_comb
   begin
      nxt_mode = mode_ff;
      nxt_ws_wake = ws_wake_ff;
      nxt_force_pend = force_pend_ff;
      nxt_enter = 1'h0;
      nxt_tag = 1'h0;
      // Failure flag: read of status clears it, a new failure wins the same cycle
      nxt_wait_stop_failure = wait_stop_failure_ff;
      if (rd_status)
      begin
         nxt_wait_stop_failure = 1'h0;
      end
      if (i_mem_fail_ws)
      begin
         nxt_wait_stop_failure = 1'h1; // RL15
      end
      // Forced match latches until the next instruction boundary
      if (addr_hit && force_or_tag_choice_ff)
      begin
         nxt_force_pend = 1'h1; // RL9
      end
      if (!breakpoint_enable_ff)
      begin
         nxt_force_pend = 1'h0; // RL8
      end
      // Tagged match marks the opcode being fetched
      nxt_tag = addr_hit && !force_or_tag_choice_ff && i_cpu_opfetch; // RL10
      unique case (mode_ff)
         dbc_pkg::mode_run:
         begin
            // Every entry path is refused while the permit bit is low
            if (background_permit_ff) // RL6
            begin
               if (bg_cmd)
               begin
                  nxt_enter = 1'h1;
                  nxt_ws_wake = i_cpu_wait_stop; // RL13
               end
               else if (force_pend_ff && i_instr_boundary && breakpoint_enable_ff)
               begin
                  nxt_enter = 1'h1; // RL9
               end
               else if (i_tag_at_queue_end && breakpoint_enable_ff)
               begin
                  nxt_enter = 1'h1; // RL10
               end
            end
            if (nxt_enter)
            begin
               nxt_mode = dbc_pkg::mode_active;
               nxt_force_pend = 1'h0;
               nxt_tag = 1'h0;
            end
         end
         dbc_pkg::mode_active:
         begin
            // Resume the user program; the wake mark is history from then on
            if (go_cmd)
            begin
               nxt_mode = dbc_pkg::mode_run;
               nxt_ws_wake = 1'h0; // RL12
            end
         end
      endcase
   end

   // Mode and status registers
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         mode_ff <= dbc_pkg::mode_run;
         ws_wake_ff <= 1'h0;
         wait_stop_failure_ff <= 1'h0;
         force_pend_ff <= 1'h0;
         enter_ff <= 1'h0;
         tag_ff <= 1'h0;
      end
      else
      begin
         mode_ff <= nxt_mode; // RL7
         ws_wake_ff <= nxt_ws_wake;
         wait_stop_failure_ff <= nxt_wait_stop_failure;
         force_pend_ff <= nxt_force_pend;
         enter_ff <= nxt_enter;
         tag_ff <= nxt_tag;
      end
   end

   // Read answers, one cycle after the command
   always_comb
   begin
      nxt_rdata = rdata_ff;
      nxt_rvalid = rd_status || rd_bkpt;
      if (rd_status)
      begin
         nxt_rdata = {8'h00, status_byte}; // RL5
      end
      else if (rd_bkpt)
      begin
         nxt_rdata = 16'(breakpoint_match_address_ff);
      end
   end

   // Read data registers
   always_ff @(posedge i_clock or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         rdata_ff <= 16'h0000;
         rvalid_ff <= 1'h0;
      end
      else
      begin
         rdata_ff <= nxt_rdata;
         rvalid_ff <= nxt_rvalid;
      end
   end

   // Outputs straight from flip-flops
   assign o_rdata_ff = rdata_ff;
   assign o_rdata_valid_ff = rvalid_ff;
   assign o_enter_bgnd_ff = enter_ff;
   assign o_opcode_tag_ff = tag_ff;
   assign o_background_active_ff = mode_ff;
   assign o_comm_clock_select_ff = comm_clock_select_ff;

   // Checks on the block's own behaviour
   a_permit_frozen: assert property (@(posedge i_clock) disable iff (!i_nrst) // RL4
      (mode_ff == dbc_pkg::mode_active) && wr_ctrl |=> $stable(background_permit_ff))
      else $error("permit bit changed while background active");

   a_entry_needs_permit: assert property (@(posedge i_clock) disable iff (!i_nrst) // RL6
      o_enter_bgnd_ff |-> $past(background_permit_ff) && $past(mode_ff) == dbc_pkg::mode_run)
      else $error("background entered without permit");

   a_active_report: assert property (@(posedge i_clock) disable iff (!i_nrst) // RL7
      rd_status |=> o_rdata_valid_ff && o_rdata_ff[6] == ($past(mode_ff) == dbc_pkg::mode_active))
      else $error("active bit misreported");

   a_bkpt_disabled: assert property (@(posedge i_clock) disable iff (!i_nrst) // RL8
      !breakpoint_enable_ff && !bg_cmd |=> !o_enter_bgnd_ff && !o_opcode_tag_ff)
      else $error("breakpoint acted while disabled");

   a_force_entry: assert property (@(posedge i_clock) disable iff (!i_nrst) // RL9
      force_pend_ff && i_instr_boundary && background_permit_ff && breakpoint_enable_ff
      && mode_ff == dbc_pkg::mode_run |=> o_enter_bgnd_ff ##1 o_background_active_ff)
      else $error("forced breakpoint missed boundary");

   a_tag_mark: assert property (@(posedge i_clock) disable iff (!i_nrst) // RL10
      addr_hit && !force_or_tag_choice_ff && i_cpu_opfetch && !nxt_enter |=> o_opcode_tag_ff)
      else $error("tagged opcode not marked");

   a_clock_select: assert property (@(posedge i_clock) disable iff (!i_nrst) // RL11
      wr_ctrl |=> o_comm_clock_select_ff == $past(i_cmd_wdata[3]))
      else $error("clock select write lost");

   a_ws_report: assert property (@(posedge i_clock) disable iff (!i_nrst) // RL12
      rd_status && i_cpu_wait_stop |=> o_rdata_ff[2])
      else $error("wait/stop flag not reported");

   a_ws_wake: assert property (@(posedge i_clock) disable iff (!i_nrst) // RL13
      bg_cmd && background_permit_ff && i_cpu_wait_stop && mode_ff == dbc_pkg::mode_run
      |=> o_enter_bgnd_ff && ws_wake_ff)
      else $error("background command did not wake");

   a_wsf_set: assert property (@(posedge i_clock) disable iff (!i_nrst) // RL15
      i_mem_fail_ws |=> wait_stop_failure_ff)
      else $error("failure flag not set");

   a_dvf_zero: assert property (@(posedge i_clock) disable iff (!i_nrst) // RL17
      o_rdata_valid_ff && $past(rd_status) |-> !o_rdata_ff[0])
      else $error("data valid failure bit rose");

endmodule

// *** dv/dbc_host_model.sv ***
// Debug host model that sends serial debug commands to the control block.
// Assumes the bench calls its tasks just after a rising clock edge.
module dbc_host_model
(
   // Clock
   input wire logic i_clock,
   // Command toward the block
   output logic o_cmd_valid,
   output dbc_pkg::dbc_cmd_t o_cmd,
   output logic [15:0] o_cmd_wdata
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle values at time zero
   initial
   begin
      o_cmd_valid = 1'b0;
      o_cmd = dbc_pkg::cmd_read_status;
      o_cmd_wdata = 16'h0000;
   end

   // One command, then a quiet cycle so the strobe is never set twice in a step
   task automatic send(input dbc_pkg::dbc_cmd_t c, input logic [15:0] d);
      o_cmd_valid = 1'b1;
      o_cmd = c;
      o_cmd_wdata = d;
      @(posedge i_clock);
      #1;
      o_cmd_valid = 1'b0;
      @(posedge i_clock);
      #1;
   endtask

   // Force background, then read status before anything else
   task automatic force_bgnd();
      send(dbc_pkg::cmd_background, 16'h0000);
      send(dbc_pkg::cmd_read_status, 16'h0000);
   endtask

   // Recovery after a failed access: background, status read, resume
   task automatic recover();
      send(dbc_pkg::cmd_background, 16'h0000);
      send(dbc_pkg::cmd_read_status, 16'h0000);
      send(dbc_pkg::cmd_go, 16'h0000);
   endtask
endmodule

// *** dv/dbc_ctrl_status_bench.sv ***
// Self-checking bench for the debug control, status and breakpoint block.
// Assumes the host model drives commands; the bench drives the processor side.
module dbc_ctrl_status_bench;
   timeunit 1ns;
   timeprecision 1ns;

   // Clock, reset and processor-side stimulus
   logic i_clock, i_nrst, access, opfetch, boundary, q_end, wait_stop, mem_fail;
   logic [15:0] addr, bkpt_addr, rdata;
   // Host link and block outputs
   logic cmd_valid, rvalid, enter, tag, active, clk_sel;
   logic [15:0] wdata;
   dbc_pkg::dbc_cmd_t cmd;
   // Expected read answers, oldest first
   logic [15:0] exp_q[$];
   int fail_count, checks, cycles, enter_cnt, tag_cnt;
   logic [31:0] seed;

   dbc_host_model host_u (.i_clock(i_clock), .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_cmd_wdata(wdata));

   dbc_ctrl_status dut_u
   (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_cmd_valid(cmd_valid), .i_cmd(cmd), .i_cmd_wdata(wdata),
      .o_rdata_ff(rdata), .o_rdata_valid_ff(rvalid), .i_cpu_access(access), .i_cpu_opfetch(opfetch),
      .i_cpu_addr(addr), .i_instr_boundary(boundary), .i_tag_at_queue_end(q_end),
      .i_cpu_wait_stop(wait_stop), .i_mem_fail_ws(mem_fail), .o_enter_bgnd_ff(enter),
      .o_opcode_tag_ff(tag), .o_background_active_ff(active), .o_comm_clock_select_ff(clk_sel)
   );

   // Free-running 50 ns clock
   initial
   begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end

   // Fixed-seed pseudo-random source
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Single comparison point
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Verdict and end of run
   task automatic print_verdict();
      if (fail_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Advance n cycles, landing just after the edge
   task automatic step(input int n);
      repeat (n)
      begin
         @(posedge i_clock);
         #1;
      end
   endtask

   // Read with its expected answer noted first
   task automatic rd(input dbc_pkg::dbc_cmd_t c, input logic [15:0] e);
      exp_q.push_back(e);
      host_u.send(c, 16'h0000);
   endtask

   // One bus access, optionally an opcode fetch
   task automatic hit(input logic [15:0] a, input logic f);
      access = 1'b1;
      opfetch = f;
      addr = a;
      step(1);
      access = 1'b0;
      opfetch = 1'b0;
   endtask

   // Instruction boundary, then time for a request to show
   task automatic bnd();
      boundary = 1'b1;
      step(1);
      boundary = 1'b0;
      step(3);
   endtask

   // Watcher: counts pulses and matches each read answer to the oldest note
   always @(negedge i_clock)
   begin
      if (enter === 1'b1)
         enter_cnt++;
      if (tag === 1'b1)
         tag_cnt++;
      if (rvalid === 1'b1)
         chk("rdata", rdata, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
   end

   // Hang guard, well above the fewer than a hundred cycles the run needs
   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         fail_count++;
         $display("MISMATCH timeout expected done seen hang");
         print_verdict();
      end
   end

   // Main sequence
   initial
   begin
      {i_nrst, access, opfetch, boundary, q_end, wait_stop, mem_fail} = 7'h00;
      addr = 16'h0000;
      seed = 32'h2a16df47;
      seed = xorshift(seed);
      bkpt_addr = seed[15:0];
      step(8);
      i_nrst = 1'b1;
      // Reset values and read-only bits
      rd(dbc_pkg::cmd_read_status, 16'h0000);
      rd(dbc_pkg::cmd_read_bkpt, 16'h0000);
      chk("clock_select", 16'(clk_sel), 16'h0000);
      host_u.send(dbc_pkg::cmd_write_control, 16'h00ff);
      rd(dbc_pkg::cmd_read_status, 16'h00b8);
      chk("clock_select", 16'(clk_sel), 16'h0001);
      host_u.send(dbc_pkg::cmd_write_bkpt, bkpt_addr);
      rd(dbc_pkg::cmd_read_bkpt, bkpt_addr);
      // Background refused without permit
      host_u.send(dbc_pkg::cmd_write_control, 16'h0038);
      host_u.send(dbc_pkg::cmd_background, 16'h0000);
      rd(dbc_pkg::cmd_read_status, 16'h0038);
      chk("active", 16'(active), 16'h0000);
      // Permitted entry, frozen permit, exit
      host_u.send(dbc_pkg::cmd_write_control, 16'h0080);
      exp_q.push_back(16'h00c0);
      host_u.force_bgnd();
      host_u.send(dbc_pkg::cmd_write_control, 16'h0000);
      rd(dbc_pkg::cmd_read_status, 16'h00c0);
      host_u.send(dbc_pkg::cmd_go, 16'h0000);
      rd(dbc_pkg::cmd_read_status, 16'h0080);
      // Only the permitted background command may have pulsed entry so far
      chk("enter_count", 16'(enter_cnt), 16'h0001);
      // Forced breakpoint: near miss, then exact hit; count breakpoint entries afresh
      enter_cnt = 0;
      host_u.send(dbc_pkg::cmd_write_control, 16'h00b0);
      hit(bkpt_addr ^ 16'h0001, 1'b0);
      bnd();
      chk("enter_count", 16'(enter_cnt), 16'h0000);
      hit(bkpt_addr, 1'b0);
      bnd();
      chk("enter_count", 16'(enter_cnt), 16'h0001);
      chk("active", 16'(active), 16'h0001);
      host_u.send(dbc_pkg::cmd_go, 16'h0000);
      // Breakpoint disabled ignores a match
      host_u.send(dbc_pkg::cmd_write_control, 16'h0090);
      hit(bkpt_addr, 1'b0);
      bnd();
      chk("enter_count", 16'(enter_cnt), 16'h0001);
      // Tagged opcode, entry at queue end
      host_u.send(dbc_pkg::cmd_write_control, 16'h00a0);
      hit(bkpt_addr, 1'b1);
      step(1);
      chk("tag_count", 16'(tag_cnt), 16'h0001);
      q_end = 1'b1;
      step(1);
      q_end = 1'b0;
      step(2);
      chk("enter_count", 16'(enter_cnt), 16'h0002);
      host_u.send(dbc_pkg::cmd_go, 16'h0000);
      // Wait/stop flag, wake by background
      wait_stop = 1'b1;
      rd(dbc_pkg::cmd_read_status, 16'h00a4);
      exp_q.push_back(16'h00e4);
      host_u.force_bgnd();
      wait_stop = 1'b0;
      rd(dbc_pkg::cmd_read_status, 16'h00e4);
      host_u.send(dbc_pkg::cmd_go, 16'h0000);
      rd(dbc_pkg::cmd_read_status, 16'h00a0);
      // Wait/stop failure flag, recovery, clear on read
      mem_fail = 1'b1;
      step(1);
      mem_fail = 1'b0;
      exp_q.push_back(16'h00e2);
      host_u.recover();
      rd(dbc_pkg::cmd_read_status, 16'h00a0);
      step(3);
      chk("pending_reads", 16'(exp_q.size()), 16'h0000);
      print_verdict();
   end
endmodule
